/* logic/timer_irq_dma_pkg.sv */
// Behaviour
// R1 - Global enable gates every timer interrupt request
// R2 - DMA masks set by software, cleared at block end
// R3 - Capture-0 irq mask serves end-of-block when DMA on
// R4 - Compare-0 irq mask serves end-of-block when DMA on
// R5 - Capture-1, compare-1, wrap masks enable their sources
// R6 - Counter pointer high bits, swap toggles lowest one
// R7 - Address pointer high bits, swap toggles lowest one
// R8 - Pointer bit 1 shows serving channel
// R9 - Counter pointer bit 0 selects memory or register file
// R10 - Address pointer bit 0 selects segment register
// R11 - Register file ignores address pointer except table bit
// R12 - Vector bits 7:3 are software base
// R13 - Vector bits 2:1 encode requesting group
// R14 - Vector bit 0 always reads zero
// R15 - Capture end flag set at swap block end, else one
// R16 - Compare end flag set at swap block end, else one
// R17 - Capture channel source select bit
// R18 - Compare channel destination select bit
// R19 - Swap enable covers both channels
// R20 - Three-bit shared priority level
// R21 - Wrap request needs flag, mask and global enable
// R22 - Compare-0 overrun on repeat request before flag clear
// R23 - Event with DMA mask gives one DMA request
// R24 - Compare-0 swap block end toggles both table bits
`default_nettype none
package timer_irq_dma_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned PRIO_W = 3;
	localparam int unsigned BASE_W = 5;
	localparam int unsigned GRP_W = 2;

	localparam logic [ADDR_W-1:0] OFS_COUNTER_PTR = 8'hf0;
	localparam logic [ADDR_W-1:0] OFS_ADDRESS_PTR = 8'hf1;
	localparam logic [ADDR_W-1:0] OFS_VECTOR_BASE = 8'hf2;
	localparam logic [ADDR_W-1:0] OFS_IRQ_DMA_CTRL = 8'hf3;
	localparam logic [ADDR_W-1:0] OFS_IRQ_DMA_MASK = 8'hff;

	localparam int unsigned BIT_GLOBAL_EN = 7;
	localparam int unsigned BIT_CAP0_DMA = 6;
	localparam int unsigned BIT_CAP0_IRQ = 5;
	localparam int unsigned BIT_CAP1_IRQ = 4;
	localparam int unsigned BIT_CMP0_DMA = 3;
	localparam int unsigned BIT_CMP0_IRQ = 2;
	localparam int unsigned BIT_CMP1_IRQ = 1;
	localparam int unsigned BIT_WRAP_IRQ = 0;

	localparam int unsigned BIT_CAP_END = 7;
	localparam int unsigned BIT_CMP_END = 6;
	localparam int unsigned BIT_CAP_SRC = 5;
	localparam int unsigned BIT_CMP_DST = 4;
	localparam int unsigned BIT_SWAP_EN = 3;
	localparam int unsigned PRIO_MSB = 2;
	localparam int unsigned PRIO_LSB = 0;

	localparam int unsigned PTR_HIGH_MSB = 7;
	localparam int unsigned PTR_HIGH_LSB = 2;
	localparam int unsigned PTR_CHAN = 1;
	localparam int unsigned PTR_SEL = 0;
	localparam int unsigned VEC_BASE_MSB = 7;
	localparam int unsigned VEC_BASE_LSB = 3;

	localparam logic [DATA_W-1:0] CTRL_RST = 8'hc7;
	localparam logic [DATA_W-1:0] MASK_RST = 8'h00;
	localparam logic [DATA_W-1:0] PTR_RST = 8'h00;
	localparam logic [BASE_W-1:0] BASE_RST = 5'h00;
	localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

	localparam logic [GRP_W-1:0] GRP_WRAP = 2'b00;
	localparam logic [GRP_W-1:0] GRP_CAPTURE = 2'b10;
	localparam logic [GRP_W-1:0] GRP_COMPARE = 2'b11;
	localparam logic CHAN_CAPTURE = 1'b0;
	localparam logic CHAN_COMPARE = 1'b1;
	localparam logic VEC_BIT0 = 1'b0;

	typedef struct packed {
		logic cap0;
		logic cap1;
		logic cmp0;
		logic cmp1;
		logic wrap;
	} timer_evt_t;

	typedef struct packed {
		logic cap0;
		logic cap1;
		logic cmp0;
		logic cmp1;
		logic wrap;
		logic and_mode;
	} timer_flag_t;

	typedef struct packed {
		logic area_reg;
		logic xfer_seg;
		logic table_sel;
		logic channel;
		logic cap_src_port;
		logic cmp_dst_port;
	} dma_ctl_t;
endpackage : timer_irq_dma_pkg
`default_nettype wire

/* logic/dma_channel_ctl.sv */
`default_nettype none
module dma_channel_ctl (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic evt_i,
	input wire logic mask_i,
	input wire logic swap_i,
	input wire logic eob_i,
	input wire logic flag_wr_i,
	input wire logic flag_wdata_i,
	input wire logic pend_clr_i,
	output logic req_o,
	output logic mask_clr_o,
	output logic eob_flag_o,
	output logic eob_pend_o
);
	logic req_r;
	logic req_nxt;
	logic flag_r;
	logic flag_nxt;
	logic pend_r;
	logic pend_nxt;
	logic block_end;

	always_comb begin
		block_end = eob_i & mask_i;
		req_nxt = evt_i & mask_i; // R23
		flag_nxt = flag_r;
		if (flag_wr_i) begin
			flag_nxt = flag_wdata_i;
		end
		if (block_end | ~swap_i) begin
			flag_nxt = 1'b1; // R15
		end
		pend_nxt = pend_r;
		if (pend_clr_i) begin
			pend_nxt = 1'b0;
		end
		if (block_end) begin
			pend_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			req_r <= 1'b0;
			flag_r <= 1'b1;
			pend_r <= 1'b0;
		end else begin
			req_r <= req_nxt;
			flag_r <= flag_nxt;
			pend_r <= pend_nxt;
		end
	end

	assign mask_clr_o = block_end; // R2
	assign req_o = req_r;
	assign eob_flag_o = flag_r;
	assign eob_pend_o = pend_r;
endmodule : dma_channel_ctl
`default_nettype wire

/* logic/irq_vector_encode.sv */
`default_nettype none
module irq_vector_encode
	import timer_irq_dma_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic global_en_i,
	input wire logic cap_src_i,
	input wire logic cmp_src_i,
	input wire logic wrap_src_i,
	input wire logic [timer_irq_dma_pkg::BASE_W-1:0] base_i,
	output logic irq_o,
	output logic [timer_irq_dma_pkg::GRP_W-1:0] group_o,
	output logic [timer_irq_dma_pkg::DATA_W-1:0] vector_o
);
	logic irq_r;
	logic irq_nxt;
	logic [GRP_W-1:0] grp_r;
	logic [GRP_W-1:0] grp_nxt;
	logic [DATA_W-1:0] vec_r;
	logic [DATA_W-1:0] vec_nxt;

	always_comb begin
		irq_nxt = global_en_i & (cap_src_i | cmp_src_i | wrap_src_i); // R1
		grp_nxt = grp_r;
		if (cap_src_i) begin
			grp_nxt = GRP_CAPTURE; // R13
		end else if (cmp_src_i) begin
			grp_nxt = GRP_COMPARE; // R13
		end else if (wrap_src_i) begin
			grp_nxt = GRP_WRAP; // R13
		end
		vec_nxt = {base_i, grp_nxt, VEC_BIT0}; // R12 R14
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			irq_r <= 1'b0;
			grp_r <= GRP_WRAP;
			vec_r <= RDATA_IDLE;
		end else begin
			irq_r <= irq_nxt;
			grp_r <= grp_nxt;
			vec_r <= vec_nxt;
		end
	end

	assign irq_o = irq_r;
	assign group_o = grp_r;
	assign vector_o = vec_r;
endmodule : irq_vector_encode
`default_nettype wire

/* logic/timer_irq_dma_ctl.sv */
// The strobed register port was left to the implementer.
`default_nettype none
module timer_irq_dma_ctl
	import timer_irq_dma_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [timer_irq_dma_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [timer_irq_dma_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [timer_irq_dma_pkg::DATA_W-1:0] reg_rdata_o,
	input wire timer_irq_dma_pkg::timer_evt_t evt_i,
	input wire timer_irq_dma_pkg::timer_flag_t flag_i,
	input wire logic overrun_clr_i,
	input wire logic cap_eob_i,
	input wire logic cmp_eob_i,
	output logic cap_dma_req_o,
	output logic cmp_dma_req_o,
	output logic irq_o,
	output logic [timer_irq_dma_pkg::DATA_W-1:0] irq_vector_o,
	output logic [timer_irq_dma_pkg::PRIO_W-1:0] priority_o,
	output logic cmp0_overrun_o,
	output timer_irq_dma_pkg::dma_ctl_t dma_ctl_o
);
	import timer_irq_dma_pkg::*;

	// Software visible state
	logic [DATA_W-1:0] mask_r;
	logic [DATA_W-1:0] mask_nxt;
	logic [DATA_W-1:0] ctrl_r;
	logic [DATA_W-1:0] ctrl_nxt;
	logic [DATA_W-1:0] cnt_ptr_r;
	logic [DATA_W-1:0] cnt_ptr_nxt;
	logic [DATA_W-1:0] adr_ptr_r;
	logic [DATA_W-1:0] adr_ptr_nxt;
	logic [BASE_W-1:0] base_r;
	logic [BASE_W-1:0] base_nxt;
	logic chan_r;
	logic chan_nxt;
	logic overrun_r;
	logic overrun_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	dma_ctl_t dma_ctl_r;
	dma_ctl_t dma_ctl_nxt;

	// Decode
	logic wr_cnt_ptr;
	logic wr_adr_ptr;
	logic wr_vector;
	logic wr_ctrl;
	logic wr_mask;
	logic rd_ctrl;

	// Channel links
	logic cap_mask_clr;
	logic cmp_mask_clr;
	logic cap_end_flag;
	logic cmp_end_flag;
	logic cap_pend;
	logic cmp_pend;
	logic cap_req;
	logic cmp_req;
	logic swap_en;
	logic table_toggle;

	// Interrupt sources
	logic cap0_src;
	logic cap1_src;
	logic cap_grp_src;
	logic cmp0_src;
	logic cmp1_src;
	logic cmp_grp_src;
	logic wrap_src;
	logic irq_w;
	logic [GRP_W-1:0] group_w;
	logic [DATA_W-1:0] vector_w;

	// Mask register fields
	logic global_timer_irq_enable;
	logic capture_zero_dma_mask;
	logic capture_zero_irq_mask;
	logic capture_one_irq_mask;
	logic compare_zero_dma_mask;
	logic compare_zero_irq_mask;
	logic compare_one_irq_mask;
	logic wrap_irq_mask;

	// Control and pointer fields
	logic capture_channel_source_sel;
	logic compare_channel_dest_sel;
	logic [PRIO_W-1:0] priority_level;
	logic [PTR_HIGH_MSB-PTR_HIGH_LSB:0] counter_pointer_high;
	logic [PTR_HIGH_MSB-PTR_HIGH_LSB:0] address_pointer_high;
	logic area_select;
	logic segment_extension_select;

	// Write decode, unmapped offsets are ignored
	always_comb begin
		wr_cnt_ptr = 1'b0;
		wr_adr_ptr = 1'b0;
		wr_vector = 1'b0;
		wr_ctrl = 1'b0;
		wr_mask = 1'b0;
		if (reg_wr_i) begin
			case (reg_addr_i)
				OFS_COUNTER_PTR: begin
					wr_cnt_ptr = 1'b1;
				end
				OFS_ADDRESS_PTR: begin
					wr_adr_ptr = 1'b1;
				end
				OFS_VECTOR_BASE: begin
					wr_vector = 1'b1;
				end
				OFS_IRQ_DMA_CTRL: begin
					wr_ctrl = 1'b1;
				end
				OFS_IRQ_DMA_MASK: begin
					wr_mask = 1'b1;
				end
				default: begin
					wr_mask = 1'b0;
				end
			endcase
		end
	end

	assign rd_ctrl = reg_rd_i & (reg_addr_i == OFS_IRQ_DMA_CTRL);
	assign swap_en = ctrl_r[BIT_SWAP_EN]; // R19

	assign global_timer_irq_enable = mask_r[BIT_GLOBAL_EN]; // R1
	assign capture_zero_dma_mask = mask_r[BIT_CAP0_DMA]; // R2
	assign capture_zero_irq_mask = mask_r[BIT_CAP0_IRQ]; // R3
	assign capture_one_irq_mask = mask_r[BIT_CAP1_IRQ]; // R5
	assign compare_zero_dma_mask = mask_r[BIT_CMP0_DMA]; // R2
	assign compare_zero_irq_mask = mask_r[BIT_CMP0_IRQ]; // R4
	assign compare_one_irq_mask = mask_r[BIT_CMP1_IRQ]; // R5
	assign wrap_irq_mask = mask_r[BIT_WRAP_IRQ]; // R5
	assign capture_channel_source_sel = ctrl_r[BIT_CAP_SRC]; // R17
	assign compare_channel_dest_sel = ctrl_r[BIT_CMP_DST]; // R18
	assign priority_level = ctrl_r[PRIO_MSB:PRIO_LSB]; // R20
	assign counter_pointer_high = cnt_ptr_r[PTR_HIGH_MSB:PTR_HIGH_LSB]; // R6
	assign address_pointer_high = adr_ptr_r[PTR_HIGH_MSB:PTR_HIGH_LSB]; // R7
	assign area_select = cnt_ptr_r[PTR_SEL]; // R9
	assign segment_extension_select = adr_ptr_r[PTR_SEL]; // R10

	// Capture 0 channel
	dma_channel_ctl u_cap_channel (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.evt_i(evt_i.cap0),
		.mask_i(capture_zero_dma_mask),
		.swap_i(swap_en),
		.eob_i(cap_eob_i),
		.flag_wr_i(wr_ctrl),
		.flag_wdata_i(reg_wdata_i[BIT_CAP_END]),
		.pend_clr_i(rd_ctrl),
		.req_o(cap_req),
		.mask_clr_o(cap_mask_clr),
		.eob_flag_o(cap_end_flag),
		.eob_pend_o(cap_pend)
	);

	// Compare 0 channel
	dma_channel_ctl u_cmp_channel (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.evt_i(evt_i.cmp0),
		.mask_i(compare_zero_dma_mask),
		.swap_i(swap_en),
		.eob_i(cmp_eob_i),
		.flag_wr_i(wr_ctrl),
		.flag_wdata_i(reg_wdata_i[BIT_CMP_END]),
		.pend_clr_i(rd_ctrl),
		.req_o(cmp_req),
		.mask_clr_o(cmp_mask_clr),
		.eob_flag_o(cmp_end_flag),
		.eob_pend_o(cmp_pend)
	);

	assign table_toggle = cmp_mask_clr & swap_en; // R24

	// Source qualification
	always_comb begin
		if (capture_zero_dma_mask) begin
			cap0_src = capture_zero_irq_mask & cap_pend; // R3
		end else begin
			cap0_src = capture_zero_irq_mask & (flag_i.cap0 | cap_pend); // R3
		end
		cap1_src = capture_one_irq_mask & flag_i.cap1; // R5
		if (flag_i.and_mode) begin
			cap_grp_src = cap0_src & cap1_src;
		end else begin
			cap_grp_src = cap0_src | cap1_src;
		end
		if (compare_zero_dma_mask) begin
			cmp0_src = compare_zero_irq_mask & cmp_pend; // R4
		end else begin
			cmp0_src = compare_zero_irq_mask & (flag_i.cmp0 | cmp_pend); // R4
		end
		cmp1_src = compare_one_irq_mask & flag_i.cmp1; // R5
		cmp_grp_src = cmp0_src | cmp1_src;
		wrap_src = wrap_irq_mask & flag_i.wrap; // R5 R21
	end

	irq_vector_encode u_vector (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.global_en_i(global_timer_irq_enable),
		.cap_src_i(cap_grp_src),
		.cmp_src_i(cmp_grp_src),
		.wrap_src_i(wrap_src),
		.base_i(base_r),
		.irq_o(irq_w),
		.group_o(group_w),
		.vector_o(vector_w)
	);

	// Register next values
	always_comb begin
		mask_nxt = mask_r;
		if (cap_mask_clr) begin
			mask_nxt[BIT_CAP0_DMA] = 1'b0; // R2
		end
		if (cmp_mask_clr) begin
			mask_nxt[BIT_CMP0_DMA] = 1'b0; // R2
		end
		if (wr_mask) begin
			mask_nxt = reg_wdata_i; // R5
		end

		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt[BIT_CMP_DST:PRIO_LSB] = reg_wdata_i[BIT_CMP_DST:PRIO_LSB]; // R18 R19 R20
			ctrl_nxt[BIT_CAP_SRC] = reg_wdata_i[BIT_CAP_SRC]; // R17
		end

		cnt_ptr_nxt = cnt_ptr_r;
		adr_ptr_nxt = adr_ptr_r;
		if (wr_cnt_ptr) begin
			cnt_ptr_nxt = reg_wdata_i; // R6 R9
		end
		if (wr_adr_ptr) begin
			adr_ptr_nxt = reg_wdata_i; // R7 R10
		end
		if (table_toggle) begin
			cnt_ptr_nxt[PTR_HIGH_LSB] = ~cnt_ptr_nxt[PTR_HIGH_LSB]; // R6
			adr_ptr_nxt[PTR_HIGH_LSB] = ~adr_ptr_nxt[PTR_HIGH_LSB]; // R7
		end
		cnt_ptr_nxt[PTR_CHAN] = 1'b0;
		adr_ptr_nxt[PTR_CHAN] = 1'b0;

		base_nxt = base_r;
		if (wr_vector) begin
			base_nxt = reg_wdata_i[VEC_BASE_MSB:VEC_BASE_LSB]; // R12
		end

		chan_nxt = chan_r;
		if (evt_i.cmp0 & compare_zero_dma_mask) begin
			chan_nxt = CHAN_COMPARE; // R8
		end else if (evt_i.cap0 & capture_zero_dma_mask) begin
			chan_nxt = CHAN_CAPTURE; // R8
		end

		overrun_nxt = overrun_r;
		if (overrun_clr_i) begin
			overrun_nxt = 1'b0;
		end
		if (evt_i.cmp0 & flag_i.cmp0) begin
			overrun_nxt = 1'b1; // R22
		end
	end

	// Read data and derived DMA controls
	always_comb begin
		rdata_nxt = RDATA_IDLE;
		if (reg_rd_i) begin
			case (reg_addr_i)
				OFS_COUNTER_PTR: begin
					rdata_nxt = {counter_pointer_high, chan_r, area_select}; // R6 R8 R9
				end
				OFS_ADDRESS_PTR: begin
					rdata_nxt = {address_pointer_high, chan_r, segment_extension_select}; // R7 R8 R10
				end
				OFS_VECTOR_BASE: begin
					rdata_nxt = {base_r, group_w, VEC_BIT0}; // R13 R14
				end
				OFS_IRQ_DMA_CTRL: begin
					rdata_nxt = ctrl_r;
					rdata_nxt[BIT_CAP_END] = cap_end_flag; // R15
					rdata_nxt[BIT_CMP_END] = cmp_end_flag; // R16
				end
				OFS_IRQ_DMA_MASK: begin
					rdata_nxt = mask_r;
				end
				default: begin
					rdata_nxt = RDATA_IDLE;
				end
			endcase
		end

		dma_ctl_nxt.area_reg = area_select; // R9
		dma_ctl_nxt.xfer_seg = ~area_select & segment_extension_select; // R10 R11
		dma_ctl_nxt.table_sel = address_pointer_high[0]; // R11
		dma_ctl_nxt.channel = chan_r; // R8
		dma_ctl_nxt.cap_src_port = capture_channel_source_sel; // R17
		dma_ctl_nxt.cmp_dst_port = compare_channel_dest_sel; // R18
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			mask_r <= MASK_RST;
			ctrl_r <= CTRL_RST;
			cnt_ptr_r <= PTR_RST;
			adr_ptr_r <= PTR_RST;
			base_r <= BASE_RST;
			chan_r <= CHAN_CAPTURE;
			overrun_r <= 1'b0;
			rdata_r <= RDATA_IDLE;
			dma_ctl_r <= '0;
		end else begin
			mask_r <= mask_nxt;
			ctrl_r <= ctrl_nxt;
			cnt_ptr_r <= cnt_ptr_nxt;
			adr_ptr_r <= adr_ptr_nxt;
			base_r <= base_nxt;
			chan_r <= chan_nxt;
			overrun_r <= overrun_nxt;
			rdata_r <= rdata_nxt;
			dma_ctl_r <= dma_ctl_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;
	assign cap_dma_req_o = cap_req; // R23
	assign cmp_dma_req_o = cmp_req; // R23
	assign irq_o = irq_w; // R1
	assign irq_vector_o = vector_w;
	assign priority_o = priority_level; // R20
	assign cmp0_overrun_o = overrun_r;
	assign dma_ctl_o = dma_ctl_r;
endmodule : timer_irq_dma_ctl
`default_nettype wire

/* bench/timer_irq_dma_props.sv */
`default_nettype none
module timer_irq_dma_props
	import timer_irq_dma_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire timer_irq_dma_pkg::timer_evt_t evt_i,
	input wire timer_irq_dma_pkg::timer_flag_t flag_i,
	input wire logic overrun_clr_i,
	input wire logic cap_dma_req_o,
	input wire logic cmp_dma_req_o,
	input wire logic irq_o,
	input wire logic [7:0] irq_vector_o,
	input wire timer_irq_dma_pkg::dma_ctl_t dma_ctl_o,
	input wire logic cmp0_overrun_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic glob_r;
	logic glob_nxt;
	always_comb begin
		glob_nxt = glob_r;
		if (reg_wr_i && reg_addr_i == OFS_IRQ_DMA_MASK) begin
			glob_nxt = reg_wdata_i[BIT_GLOBAL_EN];
		end
	end
	always_ff @(posedge sys_clk_i) begin
		glob_r <= srst_i ? 1'b0 : glob_nxt;
	end
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (srst_i);
	sequence cmp_repeat_s;
		evt_i.cmp0 && flag_i.cmp0;
	endsequence
	rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == RDATA_IDLE)
		else $error("read data not idle");
	vec_zero_a: assert property (irq_vector_o[0] == VEC_BIT0)
		else $error("vector bit 0 set");
	grp_code_a: assert property (irq_vector_o[2:1] != 2'b01)
		else $error("unused group code");
	glob_gate_a: assert property (!glob_r |=> !irq_o)
		else $error("request while globally off");
	wrap_cause_a: assert property (irq_o && irq_vector_o[2:1] == GRP_WRAP |-> $past(flag_i.wrap))
		else $error("wrap request without flag");
	cap_req_a: assert property (!evt_i.cap0 |=> !cap_dma_req_o)
		else $error("capture request without event");
	cmp_req_a: assert property (!evt_i.cmp0 |=> !cmp_dma_req_o)
		else $error("compare request without event");
	chan_cmp_a: assert property (cmp_dma_req_o |=> dma_ctl_o.channel == CHAN_COMPARE)
		else $error("channel not compare");
	chan_cap_a: assert property (cap_dma_req_o && !cmp_dma_req_o |=> dma_ctl_o.channel == CHAN_CAPTURE)
		else $error("channel not capture");
	ovr_set_a: assert property (cmp_repeat_s |=> cmp0_overrun_o)
		else $error("overrun not set");
	ovr_hold_a: assert property (cmp0_overrun_o && !overrun_clr_i |=> cmp0_overrun_o)
		else $error("overrun lost");
	ovr_clr_a: assert property (overrun_clr_i && !(evt_i.cmp0 && flag_i.cmp0) |=> !cmp0_overrun_o)
		else $error("overrun not cleared");
endmodule : timer_irq_dma_props
`default_nettype wire

/* bench/dma_far_model.sv */
`default_nettype none
module dma_far_model #(
	parameter int BLOCK = 3
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic slow_i,
	input wire logic cap_req_i,
	input wire logic cmp_req_i,
	output logic cap_eob_o,
	output logic cmp_eob_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt [2];
	int dly [2];
	logic [1:0] req;
	logic [1:0] eob = 2'b00;
	assign req = {cmp_req_i, cap_req_i};
	assign cap_eob_o = eob[0];
	assign cmp_eob_o = eob[1];
	// Counts requests per channel, ends the block after a short or long delay
	always @(posedge sys_clk_i) begin
		for (int i = 0; i < 2; i++) begin
			eob[i] <= 1'b0;
			if (srst_i) begin
				cnt[i] <= 0;
				dly[i] <= 0;
			end else if (cnt[i] + int'(req[i]) == BLOCK) begin
				cnt[i] <= 0;
				dly[i] <= slow_i ? 6 : 1;
			end else begin
				cnt[i] <= cnt[i] + int'(req[i]);
				if (dly[i] > 0) begin
					dly[i] <= dly[i] - 1;
					eob[i] <= (dly[i] == 1);
				end
			end
		end
	end
endmodule : dma_far_model
`default_nettype wire

/* bench/testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import timer_irq_dma_pkg::*;
	localparam int BLOCK = 3;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wd = 8'h00;
	logic we = 1'b0;
	logic re = 1'b0;
	logic ovr_clr = 1'b0;
	logic slow = 1'b0;
	timer_evt_t evt = '0;
	timer_flag_t flg = '0;
	logic [7:0] rdata, vec, d0, d1, d3;
	logic [2:0] prio;
	logic cap_req, cmp_req, irq, ovr, cap_eob, cmp_eob;
	dma_ctl_t ctl;
	int error_cnt = 0;
	int cmp_count = 0;
	timer_irq_dma_ctl dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdata), .evt_i(evt), .flag_i(flg), .overrun_clr_i(ovr_clr),
		.cap_eob_i(cap_eob), .cmp_eob_i(cmp_eob), .cap_dma_req_o(cap_req), .cmp_dma_req_o(cmp_req),
		.irq_o(irq), .irq_vector_o(vec), .priority_o(prio), .cmp0_overrun_o(ovr), .dma_ctl_o(ctl));
	dma_far_model #(.BLOCK(BLOCK)) far_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .slow_i(slow),
		.cap_req_i(cap_req), .cmp_req_i(cmp_req), .cap_eob_o(cap_eob), .cmp_eob_o(cmp_eob));
	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge sys_clk_i);
		we <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		addr <= a;
		re <= 1'b1;
		@(posedge sys_clk_i);
		re <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rd
	task ev(input logic cmp, input int n);
		repeat (n) begin
			@(posedge sys_clk_i);
			evt.cmp0 <= cmp;
			evt.cap0 <= !cmp;
			@(posedge sys_clk_i);
			evt <= '0;
		end
		#1;
	endtask : ev
	task wait_eob(input logic cmp, input logic [1:0] grp);
		for (int n = 0; n < 40 && (cmp ? cmp_eob : cap_eob) !== 1'b1; n++) begin
			@(posedge sys_clk_i);
			#1;
		end
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk({7'h00, irq}, 8'h01);
		chk(vec, {d0[7:3], grp, 1'b0});
	endtask : wait_eob
	task summarize;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize
	initial begin
		#100us;
		error_cnt++;
		summarize();
	end
	initial begin
		void'($urandom(7));
		repeat (10) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		#1;
		chk({5'h00, prio}, 8'h07);
		rd(8'hf3, 8'hc7);
		rd(8'hff, 8'h00);
		rd(8'h10, 8'h00);
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		d3 = 8'($urandom) & 8'h37;
		wr(8'hf0, d0);
		wr(8'hf1, d1);
		wr(8'hf2, d0);
		wr(8'hf3, d3);
		rd(8'hf0, {d0[7:2], 1'b0, d0[0]});
		rd(8'hf1, {d1[7:2], 1'b0, d1[0]});
		rd(8'hf2, {d0[7:3], 3'h0});
		rd(8'hf3, {2'h3, d3[5:0]});
		chk({5'h00, prio}, {5'h00, d3[2:0]});
		chk({4'h0, ctl.area_reg, ctl.xfer_seg, ctl.cap_src_port, ctl.cmp_dst_port},
			{4'h0, d0[0], !d0[0] && d1[0], d3[5], d3[4]});
		flg.wrap <= 1'b1;
		wr(8'hff, 8'h01);
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk({7'h00, irq}, 8'h00);
		wr(8'hff, 8'h81);
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk({7'h00, irq}, 8'h01);
		chk(vec, {d0[7:3], GRP_WRAP, 1'b0});
		flg.wrap <= 1'b0;
		wr(8'hf3, 8'h08);
		wr(8'hf3, 8'h08);
		wr(8'hf0, 8'h00);
		wr(8'hf1, 8'h00);
		wr(8'hff, 8'h8c);
		ev(1'b1, BLOCK);
		wait_eob(1'b1, GRP_COMPARE);
		rd(8'hff, 8'h84);
		rd(8'hf0, 8'h06);
		rd(8'hf1, 8'h06);
		chk({6'h00, ctl.table_sel, ctl.channel}, 8'h03);
		rd(8'hf3, 8'h48);
		@(posedge sys_clk_i);
		#1;
		chk({7'h00, irq}, 8'h00);
		slow <= 1'b1;
		wr(8'hff, 8'he0);
		ev(1'b0, BLOCK);
		wait_eob(1'b0, GRP_CAPTURE);
		rd(8'hff, 8'ha0);
		rd(8'hf0, 8'h04);
		chk({6'h00, ctl.table_sel, ctl.channel}, 8'h02);
		rd(8'hf3, 8'hc8);
		flg.cap0 <= 1'b1;
		flg.and_mode <= 1'b1;
		wr(8'hff, 8'hb0);
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk({7'h00, irq}, 8'h00);
		flg.cap1 <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk({7'h00, irq}, 8'h01);
		chk(vec, {d0[7:3], GRP_CAPTURE, 1'b0});
		flg.cap0 <= 1'b0;
		flg.cap1 <= 1'b0;
		flg.and_mode <= 1'b0;
		flg.cmp1 <= 1'b1;
		wr(8'hff, 8'h82);
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk({7'h00, irq}, 8'h01);
		chk(vec, {d0[7:3], GRP_COMPARE, 1'b0});
		flg.cmp1 <= 1'b0;
		flg.cmp0 <= 1'b1;
		ev(1'b1, 1);
		chk({7'h00, ovr}, 8'h01);
		ovr_clr <= 1'b1;
		@(posedge sys_clk_i);
		ovr_clr <= 1'b0;
		flg.cmp0 <= 1'b0;
		@(posedge sys_clk_i);
		#1;
		chk({7'h00, ovr}, 8'h00);
		wr(8'hf3, 8'h00);
		rd(8'hf3, 8'hc0);
		summarize();
	end
endmodule : testbench
bind timer_irq_dma_ctl timer_irq_dma_props props_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .evt_i(evt_i), .flag_i(flag_i), .overrun_clr_i(overrun_clr_i),
	.cap_dma_req_o(cap_dma_req_o), .cmp_dma_req_o(cmp_dma_req_o), .irq_o(irq_o),
	.irq_vector_o(irq_vector_o), .dma_ctl_o(dma_ctl_o), .cmp0_overrun_o(cmp0_overrun_o));
`default_nettype wire
